// ---- core/dma_count_map.vh ----
// register map, field layout and widths for the dma count and bulk block
`ifndef DMA_COUNT_MAP_VH
`define DMA_COUNT_MAP_VH

// byte register addresses on the microcontroller bus
`define ADDR_CH1_RD_PTR_LOW 16'hFFB6
`define ADDR_CH1_RD_PTR_HIGH 16'hFFB5
`define ADDR_CH1_WR_PTR_HIGH 16'hFFB7
`define ADDR_CH1_WR_PTR_LOW 16'hFFB8
`define ADDR_CH0_RD_PTR_HIGH 16'hFFB9
`define ADDR_CH0_RD_PTR_LOW 16'hFFBA
`define ADDR_CH0_WR_PTR_HIGH 16'hFFBB
`define ADDR_CH0_WR_PTR_LOW 16'hFFBC
`define ADDR_CH0_FILL_HIGH 16'hFFEC
`define ADDR_BULK_COUNT_HIGH 16'hFFF1
`define ADDR_BULK_COUNT_LOW 16'hFFF2
`define ADDR_CH1_FILL_HIGH 16'hFFF4
`define ADDR_BULK_CONTROL 16'hFFC0
`define ADDR_BULK_STATUS 16'hFFC1

// widths
`define BUS_ADDR_W 16
`define BYTE_W 8
`define PTR_W 11
`define COUNT_W 16
`define FIFO_W 9
`define FIFO_DEPTH 16
`define FIFO_AW 4

// reset values
`define RESET_BYTE 8'h00
`define RESET_PTR 11'h000
`define RESET_COUNT 16'h0000
`define UNMAPPED_READ 8'h00

// field positions
`define LOW_BYTE_MSB 7
`define LOW_BYTE_LSB 0
`define HIGH_BYTE_MSB 15
`define HIGH_BYTE_LSB 8
`define PTR_HIGH_MSB 10
`define PTR_HIGH_LSB 8
`define PTR_HIGH_W 3
`define PTR_RSVD_W 5
`define FIFO_LAST_BIT 8

// bulk control and status bits
`define CTRL_ENABLE_BIT 0
`define CTRL_HANDSHAKE_BIT 1
`define STAT_ENABLE_BIT 0
`define STAT_HANDSHAKE_BIT 1
`define STAT_FIFO_EMPTY_BIT 2
`define STAT_FIFO_FULL_BIT 3
`define STAT_IN_DONE_BIT 4
`define STAT_COUNT_ZERO_BIT 5

`endif

// ---- core/bulk_word_fifo.v ----
// word fifo with registered read data and valid/ready on both sides
module bulk_word_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire clk_sys_in,
  input wire arst_n_in,
  // fill side
  input wire [WIDTH-1:0] in_data_in,
  input wire in_valid_in,
  output wire in_ready_out,
  // drain side
  output wire [WIDTH-1:0] out_data_out,
  output wire out_valid_out,
  input wire out_ready_in,
  // state
  output wire empty_out,
  output wire full_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  reg [WIDTH-1:0] out_data_reg;
  reg out_valid_reg;
  wire push;
  wire pop;

  assign in_ready_out = (count_reg != DEPTH[AW:0]);
  assign push = in_valid_in && in_ready_out;
  // head word moves into the output register when it is free or being taken
  assign pop = (count_reg != {(AW+1){1'b0}}) && (!out_valid_reg || out_ready_in);
  assign out_data_out = out_data_reg;
  assign out_valid_out = out_valid_reg;
  assign empty_out = !out_valid_reg && (count_reg == {(AW+1){1'b0}});
  assign full_out = !in_ready_out;

  always @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_data_reg <= {WIDTH{1'b0}};
      out_valid_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        out_data_reg <= mem[rd_ptr_reg];
        out_valid_reg <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_reg <= 1'b0;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // bulk_word_fifo

// ---- core/dma_iso_fill_and_bulk_count.v ----
// dma iso fill snapshot, pointer mirrors and bulk packet counting
//
// What this block does
// - per channel fill level high byte, read-only
// - fill count sampled each frame start, held
// - sixteen-bit bulk count over two byte registers
// - counter handles up to 64K bulk packets
// - bulk count readable anytime, writable, resets zero
// - write pointer low byte, read-only, resets zero
// - write pointer bits 10:8 in high byte
// - per channel read pointer low byte, read-only
// - read and write pointers share 11-bit space
// - read pointer bits 10:8 in high byte
// - handshake mode: one packet, self-disable, interrupt
//
// The strobed register port was left to the implementer.
`include "dma_count_map.vh"

module dma_iso_fill_and_bulk_count (
  // clock and reset
  input wire clk_sys_in,
  input wire arst_n_in,
  // microcontroller register port
  input wire [`BUS_ADDR_W-1:0] reg_addr_in,
  input wire [`BYTE_W-1:0] reg_wr_data_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output wire [`BYTE_W-1:0] reg_rd_data_out,
  // usb buffer manager, same clock
  input wire usb_sof_in,
  input wire [`PTR_W-1:0] ch0_buffer_manager_write_pointer_in,
  input wire [`PTR_W-1:0] ch1_buffer_manager_write_pointer_in,
  // iso bytes consumed by the codec side dma, one pulse per byte
  input wire ch0_iso_byte_taken_in,
  input wire ch1_iso_byte_taken_in,
  output wire [`PTR_W-1:0] ch0_dma_read_pointer_out,
  output wire [`PTR_W-1:0] ch1_dma_read_pointer_out,
  // bulk out stream from the usb buffer manager
  input wire [`BYTE_W-1:0] bulk_data_in,
  input wire bulk_last_in,
  input wire bulk_valid_in,
  output wire bulk_ready_out,
  // bulk out stream toward the codec port
  output wire [`BYTE_W-1:0] cport_data_out,
  output wire cport_last_out,
  output wire cport_valid_out,
  input wire cport_ready_in,
  // packet done request to the microcontroller
  output wire bulk_packet_done_out
);

  // registers
  reg [`PTR_W-1:0] ch0_write_pointer_reg;
  reg [`PTR_W-1:0] ch1_write_pointer_reg;
  reg [`PTR_W-1:0] ch0_read_pointer_reg;
  reg [`PTR_W-1:0] ch1_read_pointer_reg;
  reg [`BYTE_W-1:0] ch0_fill_high_reg;
  reg [`BYTE_W-1:0] ch1_fill_high_reg;
  reg [`COUNT_W-1:0] bulk_packets_remaining_reg;
  reg [`COUNT_W-1:0] bulk_packets_remaining_next;
  reg channel_enable_reg;
  reg channel_enable_next;
  reg handshake_mode_enable_reg;
  reg in_packet_done_reg;
  reg in_packet_done_next;
  reg packet_done_reg;
  reg [`BYTE_W-1:0] rd_data_reg;
  reg [`BYTE_W-1:0] rd_data_next;

  // fifo wiring
  wire [`FIFO_W-1:0] fifo_in_word;
  wire [`FIFO_W-1:0] fifo_out_word;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire fifo_empty;
  wire fifo_full;

  // decoded bus events
  wire wr_control;
  wire wr_count_low;
  wire wr_count_high;
  wire in_last_taken;
  wire out_last_taken;

  // occupancy of the iso buffer in bytes; both pointers live in one
  // 11-bit space, so the plain difference wraps correctly
  function [`BYTE_W-1:0] fill_high;
    input [`PTR_W-1:0] wr_ptr;
    input [`PTR_W-1:0] rd_ptr;
    reg [`COUNT_W-1:0] level;
    begin
      level = {{(`COUNT_W-`PTR_W){1'b0}}, wr_ptr - rd_ptr};
      fill_high = level[`HIGH_BYTE_MSB:`HIGH_BYTE_LSB];
    end
  endfunction

  // high byte of a pointer: bits 10:8 in 2:0, reserved bits read zero
  function [`BYTE_W-1:0] ptr_high;
    input [`PTR_W-1:0] ptr;
    begin
      ptr_high = {{`PTR_RSVD_W{1'b0}}, ptr[`PTR_HIGH_MSB:`PTR_HIGH_LSB]};
    end
  endfunction

  function [`BYTE_W-1:0] ptr_low;
    input [`PTR_W-1:0] ptr;
    begin
      ptr_low = ptr[`LOW_BYTE_MSB:`LOW_BYTE_LSB];
    end
  endfunction

  function reg_hit;
    input [`BUS_ADDR_W-1:0] addr;
    input [`BUS_ADDR_W-1:0] target;
    begin
      reg_hit = (addr == target);
    end
  endfunction

  assign wr_control = reg_wr_in && reg_hit(reg_addr_in, `ADDR_BULK_CONTROL);
  assign wr_count_low = reg_wr_in && reg_hit(reg_addr_in, `ADDR_BULK_COUNT_LOW);
  assign wr_count_high = reg_wr_in && reg_hit(reg_addr_in, `ADDR_BULK_COUNT_HIGH);

  // ------------------------------------------------------------------
  // iso pointers and fill snapshot
  // ------------------------------------------------------------------

  // write pointers are mirrored one cycle behind the buffer manager so
  // the bus read and the fill snapshot see a stable flop value
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ch0_write_pointer_reg <= `RESET_PTR;
      ch1_write_pointer_reg <= `RESET_PTR;
    end else begin
      ch0_write_pointer_reg <= ch0_buffer_manager_write_pointer_in;
      ch1_write_pointer_reg <= ch1_buffer_manager_write_pointer_in;
    end
  end

  // read pointers advance once per consumed byte and wrap at 2048
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ch0_read_pointer_reg <= `RESET_PTR;
      ch1_read_pointer_reg <= `RESET_PTR;
    end else begin
      if (ch0_iso_byte_taken_in) begin
        ch0_read_pointer_reg <= ch0_read_pointer_reg + 1'b1;
      end
      if (ch1_iso_byte_taken_in) begin
        ch1_read_pointer_reg <= ch1_read_pointer_reg + 1'b1;
      end
    end
  end

  assign ch0_dma_read_pointer_out = ch0_read_pointer_reg;
  assign ch1_dma_read_pointer_out = ch1_read_pointer_reg;

  // snapshot only at frame start; the value is frozen for the frame so
  // firmware never sees a count that is mid-update
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ch0_fill_high_reg <= `RESET_BYTE;
      ch1_fill_high_reg <= `RESET_BYTE;
    end else if (usb_sof_in) begin
      ch0_fill_high_reg <= fill_high(ch0_write_pointer_reg,
        ch0_read_pointer_reg);
      ch1_fill_high_reg <= fill_high(ch1_write_pointer_reg,
        ch1_read_pointer_reg);
    end
  end

  // ------------------------------------------------------------------
  // bulk out path
  // ------------------------------------------------------------------

  // in handshake mode the fill side closes after one packet's last word
  // so a second packet waits in the buffer manager, not in our fifo
  assign fifo_in_word = {bulk_last_in, bulk_data_in};
  assign fifo_in_valid = bulk_valid_in && channel_enable_reg && !in_packet_done_reg;
  assign bulk_ready_out = fifo_in_ready && channel_enable_reg && !in_packet_done_reg;
  assign in_last_taken = fifo_in_valid && fifo_in_ready && bulk_last_in;

  assign cport_valid_out = fifo_out_valid && channel_enable_reg;
  assign fifo_out_ready = cport_ready_in && channel_enable_reg;
  assign cport_data_out = fifo_out_word[`LOW_BYTE_MSB:`LOW_BYTE_LSB];
  assign cport_last_out = fifo_out_word[`FIFO_LAST_BIT];
  assign out_last_taken = cport_valid_out && cport_ready_in && cport_last_out;

  bulk_word_fifo #(
    .WIDTH(`FIFO_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_bulk_fifo (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .in_data_in(fifo_in_word),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .out_data_out(fifo_out_word),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .empty_out(fifo_empty),
    .full_out(fifo_full)
  );

  // enable, input-closed flag and packet counter next values
  always @* begin
    channel_enable_next = channel_enable_reg;
    in_packet_done_next = in_packet_done_reg;
    bulk_packets_remaining_next = bulk_packets_remaining_reg;
    if (handshake_mode_enable_reg && in_last_taken) begin
      in_packet_done_next = 1'b1;
    end
    if (handshake_mode_enable_reg && out_last_taken) begin
      channel_enable_next = 1'b0;
      in_packet_done_next = 1'b0;
      bulk_packets_remaining_next = bulk_packets_remaining_reg - 1'b1;
    end
    // a software byte load wins over the hardware decrement in the same cycle for that byte; the other byte takes the decrement
    if (wr_count_low) begin
      bulk_packets_remaining_next[`LOW_BYTE_MSB:`LOW_BYTE_LSB] = reg_wr_data_in;
      if (!(handshake_mode_enable_reg && out_last_taken)) begin
        bulk_packets_remaining_next[`HIGH_BYTE_MSB:`HIGH_BYTE_LSB] =
          bulk_packets_remaining_reg[`HIGH_BYTE_MSB:`HIGH_BYTE_LSB];
      end
    end
    if (wr_count_high) begin
      bulk_packets_remaining_next[`HIGH_BYTE_MSB:`HIGH_BYTE_LSB] = reg_wr_data_in;
      if (!(handshake_mode_enable_reg && out_last_taken)) begin
        bulk_packets_remaining_next[`LOW_BYTE_MSB:`LOW_BYTE_LSB] =
          bulk_packets_remaining_reg[`LOW_BYTE_MSB:`LOW_BYTE_LSB];
      end
    end
    // software setting the enable re-opens the fill side for a packet
    if (wr_control) begin
      channel_enable_next = reg_wr_data_in[`CTRL_ENABLE_BIT];
      if (reg_wr_data_in[`CTRL_ENABLE_BIT] && !in_last_taken) begin
        in_packet_done_next = 1'b0;
      end
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      channel_enable_reg <= 1'b0;
      handshake_mode_enable_reg <= 1'b0;
      in_packet_done_reg <= 1'b0;
      bulk_packets_remaining_reg <= `RESET_COUNT;
      packet_done_reg <= 1'b0;
    end else begin
      channel_enable_reg <= channel_enable_next;
      in_packet_done_reg <= in_packet_done_next;
      bulk_packets_remaining_reg <= bulk_packets_remaining_next;
      if (wr_control) begin
        handshake_mode_enable_reg <= reg_wr_data_in[`CTRL_HANDSHAKE_BIT];
      end
      packet_done_reg <= handshake_mode_enable_reg && out_last_taken;
    end
  end

  // registered so the request is a clean one-cycle pulse for the mcu
  assign bulk_packet_done_out = packet_done_reg;

  // ------------------------------------------------------------------
  // register read
  // ------------------------------------------------------------------

  // reads have no side effects, so firmware may poll at any time
  always @* begin
    rd_data_next = `UNMAPPED_READ;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `ADDR_CH0_FILL_HIGH: begin
          rd_data_next = ch0_fill_high_reg;
        end
        `ADDR_CH1_FILL_HIGH: begin
          rd_data_next = ch1_fill_high_reg;
        end
        `ADDR_BULK_COUNT_LOW: begin
          rd_data_next = bulk_packets_remaining_reg[`LOW_BYTE_MSB:`LOW_BYTE_LSB];
        end
        `ADDR_BULK_COUNT_HIGH: begin
          rd_data_next = bulk_packets_remaining_reg[`HIGH_BYTE_MSB:`HIGH_BYTE_LSB];
        end
        `ADDR_CH0_WR_PTR_LOW: begin
          rd_data_next = ptr_low(ch0_write_pointer_reg);
        end
        `ADDR_CH1_WR_PTR_LOW: begin
          rd_data_next = ptr_low(ch1_write_pointer_reg);
        end
        `ADDR_CH0_WR_PTR_HIGH: begin
          rd_data_next = ptr_high(ch0_write_pointer_reg);
        end
        `ADDR_CH1_WR_PTR_HIGH: begin
          rd_data_next = ptr_high(ch1_write_pointer_reg);
        end
        `ADDR_CH0_RD_PTR_LOW: begin
          rd_data_next = ptr_low(ch0_read_pointer_reg);
        end
        `ADDR_CH1_RD_PTR_LOW: begin
          rd_data_next = ptr_low(ch1_read_pointer_reg);
        end
        `ADDR_CH0_RD_PTR_HIGH: begin
          rd_data_next = ptr_high(ch0_read_pointer_reg);
        end
        `ADDR_CH1_RD_PTR_HIGH: begin
          rd_data_next = ptr_high(ch1_read_pointer_reg);
        end
        `ADDR_BULK_CONTROL: begin
          rd_data_next[`CTRL_ENABLE_BIT] = channel_enable_reg;
          rd_data_next[`CTRL_HANDSHAKE_BIT] = handshake_mode_enable_reg;
        end
        `ADDR_BULK_STATUS: begin
          rd_data_next[`STAT_ENABLE_BIT] = channel_enable_reg;
          rd_data_next[`STAT_HANDSHAKE_BIT] = handshake_mode_enable_reg;
          rd_data_next[`STAT_FIFO_EMPTY_BIT] = fifo_empty;
          rd_data_next[`STAT_FIFO_FULL_BIT] = fifo_full;
          rd_data_next[`STAT_IN_DONE_BIT] = in_packet_done_reg;
          rd_data_next[`STAT_COUNT_ZERO_BIT] =
            (bulk_packets_remaining_reg == `RESET_COUNT);
        end
        default: begin
          rd_data_next = `UNMAPPED_READ;
        end
      endcase
    end
  end

  // data stands only in the cycle after the strobe, zero otherwise
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_reg <= `RESET_BYTE;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign reg_rd_data_out = rd_data_reg;

endmodule // dma_iso_fill_and_bulk_count

// ---- tb/usb_side_model.sv ----
// usb buffer manager stand-in: bulk out source and iso write pointers
module usb_side_model (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // bench control
  input wire logic send_in,
  input wire logic [5:0] len_in,
  input wire logic step_in,
  // bulk out stream
  input wire logic bulk_ready_in,
  output logic [7:0] bulk_data_out,
  output logic bulk_last_out,
  output logic bulk_valid_out,
  // iso write pointers
  output logic [10:0] ch0_wr_ptr_out,
  output logic [10:0] ch1_wr_ptr_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] seq_reg;
  logic [5:0] left_reg;
  // released data shows the inverse so a stale byte cannot pass for a match
  assign bulk_data_out = bulk_valid_out ? seq_reg : ~seq_reg;
  assign bulk_last_out = bulk_valid_out && left_reg == 6'h01;
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      seq_reg <= 8'h00;
      left_reg <= 6'h00;
      bulk_valid_out <= 1'b0;
      ch0_wr_ptr_out <= 11'h000;
      ch1_wr_ptr_out <= 11'h000;
    end else begin
      // pointers wrap inside the shared 11-bit space
      if (step_in) begin
        ch0_wr_ptr_out <= ch0_wr_ptr_out + 11'($urandom_range(1500, 1));
        ch1_wr_ptr_out <= ch1_wr_ptr_out + 11'($urandom_range(1500, 1));
      end
      // a word is held until ready is seen at an edge
      if (bulk_valid_out && bulk_ready_in) begin
        seq_reg <= seq_reg + 8'h01;
        left_reg <= left_reg - 6'h01;
        bulk_valid_out <= left_reg != 6'h01;
      end else if (send_in && !bulk_valid_out) begin
        left_reg <= len_in;
        bulk_valid_out <= 1'b1;
      end
    end
  end
endmodule // usb_side_model

// ---- tb/dma_count_chk.sv ----
// concurrent checks on the ports of the dma fill, pointer and bulk count block
module dma_count_chk (
  // clock and reset
  input wire clk_sys_in,
  input wire arst_n_in,
  // register port
  input wire [15:0] reg_addr_in,
  input wire [7:0] reg_wr_data_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rd_data_out,
  // iso side
  input wire usb_sof_in,
  input wire [10:0] ch0_buffer_manager_write_pointer_in,
  input wire [10:0] ch1_buffer_manager_write_pointer_in,
  input wire ch0_iso_byte_taken_in,
  input wire ch1_iso_byte_taken_in,
  input wire [10:0] ch0_dma_read_pointer_out,
  input wire [10:0] ch1_dma_read_pointer_out,
  // bulk streams
  input wire [7:0] bulk_data_in,
  input wire bulk_last_in,
  input wire bulk_valid_in,
  input wire bulk_ready_out,
  input wire [7:0] cport_data_out,
  input wire cport_last_out,
  input wire cport_valid_out,
  input wire cport_ready_in,
  input wire bulk_packet_done_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // fill snapshot: the write pointer is seen one cycle late
  logic [10:0] wr0_prev;
  logic [10:0] fill0;
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr0_prev <= 11'h000;
      fill0 <= 11'h000;
    end else begin
      wr0_prev <= ch0_buffer_manager_write_pointer_in;
      if (usb_sof_in) begin
        fill0 <= wr0_prev - ch0_dma_read_pointer_out;
      end
    end
  end
  sequence s_read(logic [15:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  sequence s_last_taken;
    cport_valid_out && cport_ready_in && cport_last_out;
  endsequence
  property p_read_idle;
    !reg_rd_in |=> reg_rd_data_out == 8'h00;
  endproperty
  property p_wr0_low;
    s_read(16'hFFBC) ##0 $stable(ch0_buffer_manager_write_pointer_in)
      |=> reg_rd_data_out == $past(ch0_buffer_manager_write_pointer_in[7:0]);
  endproperty
  property p_wr1_high;
    s_read(16'hFFB7) ##0 $stable(ch1_buffer_manager_write_pointer_in)
      |=> reg_rd_data_out == {5'h00, $past(ch1_buffer_manager_write_pointer_in[10:8])};
  endproperty
  property p_rd1_low;
    s_read(16'hFFB6) |=> reg_rd_data_out == $past(ch1_dma_read_pointer_out[7:0]);
  endproperty
  property p_rd0_high;
    s_read(16'hFFB9) |=> reg_rd_data_out == {5'h00, $past(ch0_dma_read_pointer_out[10:8])};
  endproperty
  property p_rd0_step;
    ch0_dma_read_pointer_out == $past(ch0_dma_read_pointer_out)
      + 11'($past(ch0_iso_byte_taken_in));
  endproperty
  property p_fill0;
    s_read(16'hFFEC) |=> reg_rd_data_out == {5'h00, $past(fill0[10:8])};
  endproperty
  property p_done_cause;
    bulk_packet_done_out |-> $past(cport_valid_out) && $past(cport_ready_in)
      && $past(cport_last_out);
  endproperty
  property p_done_closes;
    bulk_packet_done_out |-> !cport_valid_out && !bulk_ready_out;
  endproperty
  property p_cport_hold;
    cport_valid_out && !cport_ready_in
      |=> cport_valid_out && $stable(cport_data_out) && $stable(cport_last_out);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not idle");
  a_wr0_low: assert property (p_wr0_low) else $error("write pointer low wrong");
  a_wr1_high: assert property (p_wr1_high) else $error("write pointer high wrong");
  a_rd1_low: assert property (p_rd1_low) else $error("read pointer low wrong");
  a_rd0_high: assert property (p_rd0_high) else $error("read pointer high wrong");
  a_rd0_step: assert property (p_rd0_step) else $error("read pointer step wrong");
  a_fill0: assert property (p_fill0) else $error("fill snapshot wrong");
  a_done_cause: assert property (p_done_cause) else $error("done without last");
  a_done_closes: assert property (p_done_closes) else $error("channel still open");
  a_cport_hold: assert property (p_cport_hold) else $error("codec word not held");
  c_done: cover property (s_last_taken ##1 bulk_packet_done_out);
endmodule // dma_count_chk

bind dma_iso_fill_and_bulk_count dma_count_chk dma_count_chk_i (.*);

// ---- tb/testbench.sv ----
// self-checking bench for the dma fill, pointer and bulk count block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [15:0] reg_addr_in = 16'h0000;
  logic [7:0] reg_wr_data_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic usb_sof_in = 1'b0;
  logic ch0_iso_byte_taken_in = 1'b0;
  logic ch1_iso_byte_taken_in = 1'b0;
  logic cport_ready_in = 1'b0;
  logic send = 1'b0;
  logic step = 1'b0;
  logic stall = 1'b1;
  logic [5:0] len = 6'h01;
  wire [7:0] reg_rd_data_out, bulk_data_in, cport_data_out;
  wire [10:0] wr0, wr1, rd0, rd1;
  wire bulk_last_in, bulk_valid_in, bulk_ready_out, cport_last_out, cport_valid_out, done;
  int bad_count = 0;
  int total_checks = 0;
  int idx = 0;
  logic [7:0] exp_byte = 8'h00;
  logic [5:0] len_q [$];
  logic [10:0] rd0_exp = 11'h000;
  logic [10:0] rd1_exp = 11'h000;
  logic [15:0] map [14] = '{16'hFFEC, 16'hFFF4, 16'hFFF1, 16'hFFF2, 16'hFFBC, 16'hFFBB,
    16'hFFB8, 16'hFFB7, 16'hFFBA, 16'hFFB9, 16'hFFB6, 16'hFFB5, 16'hFFBD, 16'hFFC0};
  logic [15:0] cnt [4] = '{16'h0000, 16'h0001, 16'h8000, 16'hFFFF};
  dma_iso_fill_and_bulk_count dma_iso_fill_and_bulk_count_i (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wr_data_in(reg_wr_data_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rd_data_out(reg_rd_data_out), .usb_sof_in(usb_sof_in),
    .ch0_buffer_manager_write_pointer_in(wr0), .ch1_buffer_manager_write_pointer_in(wr1),
    .ch0_iso_byte_taken_in(ch0_iso_byte_taken_in),
    .ch1_iso_byte_taken_in(ch1_iso_byte_taken_in),
    .ch0_dma_read_pointer_out(rd0), .ch1_dma_read_pointer_out(rd1),
    .bulk_data_in(bulk_data_in), .bulk_last_in(bulk_last_in), .bulk_valid_in(bulk_valid_in),
    .bulk_ready_out(bulk_ready_out), .cport_data_out(cport_data_out),
    .cport_last_out(cport_last_out), .cport_valid_out(cport_valid_out),
    .cport_ready_in(cport_ready_in), .bulk_packet_done_out(done));
  usb_side_model usb_side_model_i (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .send_in(send), .len_in(len),
    .step_in(step), .bulk_ready_in(bulk_ready_out), .bulk_data_out(bulk_data_in),
    .bulk_last_out(bulk_last_in), .bulk_valid_out(bulk_valid_in),
    .ch0_wr_ptr_out(wr0), .ch1_wr_ptr_out(wr1));
  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) cport_ready_in <= stall ? ($urandom_range(3, 0) == 0) : 1'b1;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic give_up;
    bad_count++;
    finish_test();
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wr_data_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_sys_in) check(reg_rd_data_out, e);
    @(posedge clk_sys_in);
  endtask
  task automatic send_pkt(input logic [5:0] n);
    int i;
    for (i = 0; i < 900 && bulk_valid_in !== 1'b0; i++) @(posedge clk_sys_in);
    if (i == 900) give_up();
    len_q.push_back(n);
    send <= 1'b1;
    len <= n;
    @(posedge clk_sys_in);
    send <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic wait_done;
    int i;
    for (i = 0; i < 900; i++) begin
      @(negedge clk_sys_in);
      if (done === 1'b1) break;
    end
    if (i == 900) give_up();
    @(posedge clk_sys_in);
  endtask
  function automatic logic [7:0] fill_hi(input logic [10:0] w, input logic [10:0] r);
    logic [10:0] d;
    d = w - r;
    return {5'h00, d[10:8]};
  endfunction

  // codec side: bytes in order, last flag on the packet's final byte
  always @(posedge clk_sys_in) begin
    if (arst_n_in && cport_valid_out === 1'b1 && cport_ready_in) begin
      check(cport_data_out, exp_byte);
      check(cport_last_out, idx + 1 == len_q[0]);
      exp_byte <= exp_byte + 8'h01;
      idx = cport_last_out ? 0 : idx + 1;
      if (cport_last_out === 1'b1) void'(len_q.pop_front());
    end
  end

  initial begin
    logic [15:0] c;
    logic [7:0] f0, f1, e;
    int k, n;
    void'($urandom(7));
    repeat (8) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    // writes to read-only places must be dropped
    wr(16'hFFBC, 8'hFF);
    wr(16'hFFEC, 8'hFF);
    foreach (map[i]) rd(map[i], 8'h00);
    rd(16'hFFC1, 8'h24);
    for (k = 0; k < 6; k++) begin
      c = (k == 0) ? 16'hFFFF : 16'($urandom);
      wr(16'hFFF2, c[7:0]);
      wr(16'hFFF1, c[15:8]);
      rd(16'hFFF2, c[7:0]);
      rd(16'hFFF1, c[15:8]);
    end
    for (k = 0; k < 8; k++) begin
      n = $urandom_range(700, 400);
      repeat (n) begin
        ch0_iso_byte_taken_in <= ($urandom_range(3, 0) != 0);
        ch1_iso_byte_taken_in <= ($urandom_range(1, 0) != 0);
        @(posedge clk_sys_in);
        rd0_exp += 11'(ch0_iso_byte_taken_in);
        rd1_exp += 11'(ch1_iso_byte_taken_in);
      end
      ch0_iso_byte_taken_in <= 1'b0;
      ch1_iso_byte_taken_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      check(rd0, rd0_exp);
      check(rd1, rd1_exp);
      rd(16'hFFBC, wr0[7:0]);
      rd(16'hFFB8, wr1[7:0]);
      rd(16'hFFBB, {5'h00, wr0[10:8]});
      rd(16'hFFB7, {5'h00, wr1[10:8]});
      rd(16'hFFBA, rd0_exp[7:0]);
      rd(16'hFFB6, rd1_exp[7:0]);
      rd(16'hFFB9, {5'h00, rd0_exp[10:8]});
      rd(16'hFFB5, {5'h00, rd1_exp[10:8]});
      f0 = fill_hi(wr0, rd0_exp);
      f1 = fill_hi(wr1, rd1_exp);
      usb_sof_in <= 1'b1;
      @(posedge clk_sys_in);
      usb_sof_in <= 1'b0;
      // pointers move after the frame start; the snapshot must not follow
      step <= 1'b1;
      @(posedge clk_sys_in);
      step <= 1'b0;
      rd(16'hFFEC, f0);
      rd(16'hFFF4, f1);
    end
    // handshake mode with the codec stalling; packets of 1 to 40 bytes against the 16-word buffer
    foreach (cnt[j]) begin
      wr(16'hFFF2, cnt[j][7:0]);
      wr(16'hFFF1, cnt[j][15:8]);
      wr(16'hFFC0, 8'h03);
      send_pkt(6'($urandom_range(40, 1)));
      wait_done();
      c = cnt[j] - 16'h0001;
      rd(16'hFFF2, c[7:0]);
      rd(16'hFFF1, c[15:8]);
    end
    e = exp_byte;
    send_pkt(6'h05);
    repeat (50) @(posedge clk_sys_in);
    check(exp_byte, e);
    wr(16'hFFC0, 8'h03);
    wait_done();
    check(exp_byte, e + 8'h05);
    // streaming mode leaves the count alone
    stall <= 1'b0;
    wr(16'hFFF2, 8'h34);
    wr(16'hFFF1, 8'h12);
    wr(16'hFFC0, 8'h01);
    send_pkt(6'h11);
    send_pkt(6'h03);
    for (k = 0; k < 3000 && len_q.size() > 0; k++) @(posedge clk_sys_in);
    if (k == 3000) give_up();
    rd(16'hFFF2, 8'h34);
    rd(16'hFFF1, 8'h12);
    finish_test();
  end
endmodule // testbench
